// ==== t2c_pkg.sv ====
// Constants and types shared by the timer-2 control and status block
`default_nettype none
package t2c_pkg;

  typedef logic [7:0] t2c_byte_t;
  typedef logic [15:0] t2c_word_t;

  // ----------------------------------------------------------------
  // Register addresses in the direct-address space
  // ----------------------------------------------------------------
  localparam t2c_byte_t T2C_ADDR_CTRL = 8'hC8;
  localparam t2c_byte_t T2C_ADDR_MODE = 8'hC9;
  localparam t2c_byte_t T2C_ADDR_RCAP_L = 8'hCA;
  localparam t2c_byte_t T2C_ADDR_RCAP_H = 8'hCB;
  localparam t2c_byte_t T2C_ADDR_CNT_L = 8'hCC;
  localparam t2c_byte_t T2C_ADDR_CNT_H = 8'hCD;
  localparam t2c_byte_t T2C_ADDR_INTEN = 8'hA8;
  localparam t2c_byte_t T2C_ADDR_PRIO = 8'hB8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int T2C_BIT_TF = 7;
  localparam int T2C_BIT_EXF = 6;
  localparam int T2C_BIT_RXSEL = 5;
  localparam int T2C_BIT_TXSEL = 4;
  localparam int T2C_BIT_EXEN = 3;
  localparam int T2C_BIT_TR = 2;
  localparam int T2C_BIT_CT = 1;
  localparam int T2C_BIT_CPRL = 0;
  localparam int T2C_BIT_DOWN = 0;
  localparam int T2C_BIT_OE = 1;
  localparam int T2C_BIT_EA = 7;
  localparam int T2C_BIT_ET2 = 5;
  localparam int T2C_BIT_PT2 = 5;

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam t2c_byte_t T2C_RST_CTRL = 8'h00;
  localparam t2c_byte_t T2C_RST_MODE = 8'h00;
  localparam t2c_byte_t T2C_RST_INTEN = 8'h00;
  localparam t2c_byte_t T2C_RST_PRIO = 8'h00;
  localparam t2c_word_t T2C_RST_RCAP = 16'h0000;
  localparam t2c_word_t T2C_RST_CNT = 16'h0000;
  localparam t2c_byte_t T2C_MASK_MODE = 8'h03;
  localparam t2c_byte_t T2C_MASK_INTEN = 8'hBF;
  localparam t2c_byte_t T2C_MASK_PRIO = 8'h3F;
  localparam t2c_word_t T2C_CNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Timing counts in oscillator clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] T2C_MC_CLKS = 4'hC;
  localparam logic [3:0] T2C_STATE_CLKS = 4'h2;

  typedef enum logic [1:0] {
    T2C_OFF,
    T2C_RELOAD,
    T2C_CAPTURE,
    T2C_BAUD
  } t2c_mode_e;

endpackage
`default_nettype wire

// ==== t2c_edge_if.sv ====
// Synchronised pin level and falling-edge pulse carrier
`timescale 1ns/1ps
`default_nettype none
interface t2c_edge_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// ==== t2c_pin_sync.sv ====
// Two-flop pin synchroniser with falling-edge detect
`timescale 1ns/1ps
`default_nettype none
module t2c_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  t2c_edge_if.src edge_o
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  // Idle pins read high, so reset to 1 to avoid a false edge
  always_comb begin
    s1_d = pin_i;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign edge_o.level = s2_q;
  assign edge_o.fall = s3_q & ~s2_q;
endmodule
`default_nettype wire

// ==== t2c_timer2.sv ====
// Timer 2 control, status, counter and capture/reload registers
//
// Contract
// - Overflow sets overflow_flag bit 7; only software clears it.
// - No overflow_flag set while rx or tx clock select is 1.
// - Trigger edge causing capture/reload with external_enable sets external_flag bit 6.
// - Enabled timer interrupt is requested by a set external_flag.
// - external_flag requests no interrupt while down_count_enable is 1.
// - Rx clock select bit 5 picks this timer's overflows, else other timer's.
// - Tx clock select bit 4 picks this timer's overflows, else other timer's.
// - external_enable bit 3: trigger edge captures/reloads unless clocking serial port.
// - external_enable 0 ignores trigger edges; the pin still sets count direction while down_count_enable is 1.
// - run_control bit 2 starts the timer at 1, stops it at 0.
// - counter_select bit 1: 0 timer, 1 counts falling event_count_input edges.
// - capture_reload_select 1 with external_enable: trigger edge captures count.
// - capture_reload_select 0: reload on overflow, and on trigger edge if enabled.
// - Serial clock select forces auto-reload on overflow, ignoring capture select.
// - Capture/reload pair holds the 16-bit capture or reload value.
// - Reserved bits reset and read as 0.
// - Enable register gates the timer request; priority register sets its level.
// - down_count_enable bit 0 of mode register permits up/down; reset 0.
// - trigger_input is a port pin: trigger and count direction.
`timescale 1ns/1ps
`default_nettype none
module t2c_timer2 (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire t2c_pkg::t2c_byte_t SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire t2c_pkg::t2c_byte_t SFR_WDATA_I,
  input wire logic SFR_RD_I,
  input wire logic SFR_BIT_WR_I,
  input wire logic [2:0] SFR_BIT_SEL_I,
  input wire logic SFR_BIT_VAL_I,
  input wire logic TRIG_PIN_I,
  input wire logic EVENT_PIN_I,
  input wire logic TIMER1_OVF_I,
  output var t2c_pkg::t2c_byte_t SFR_RDATA_O,
  output var logic TIMER_IRQ_O,
  output var logic TIMER_IRQ_HIPRI_O,
  output var t2c_pkg::t2c_byte_t INT_EN_O,
  output var t2c_pkg::t2c_byte_t INT_PRIO_O,
  output var logic RX_CLK_TICK_O,
  output var logic TX_CLK_TICK_O
);
  import t2c_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  t2c_edge_if trig ();
  t2c_edge_if evt ();

  // Trigger pin doubles as capture/reload strobe and count direction
  t2c_pin_sync u_trig_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .pin_i(TRIG_PIN_I),
    .edge_o(trig)
  );

  t2c_pin_sync u_evt_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .pin_i(EVENT_PIN_I),
    .edge_o(evt)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  t2c_byte_t ctrl_q, ctrl_d;
  t2c_byte_t mode_q, mode_d;
  t2c_byte_t inten_q, inten_d;
  t2c_byte_t prio_q, prio_d;
  t2c_word_t rcap_q, rcap_d;
  t2c_word_t cnt_q, cnt_d;
  logic [3:0] pre_q, pre_d;
  t2c_byte_t rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic hipri_q, hipri_d;
  logic rx_tick_q, rx_tick_d;
  logic tx_tick_q, tx_tick_d;

  t2c_mode_e mode;
  logic baud, down_en, inc, mc_tick, st_tick;
  logic trig_ev, ovf, set_tf, set_exf, tog_exf, reload_dir_up;
  logic wr_ctrl, wr_cnt, wr_rcap;
  t2c_byte_t ctrl_sw;

  // ----------------------------------------------------------------
  // Mode decode and count strobe
  // ----------------------------------------------------------------
  always_comb begin
    baud = ctrl_q[T2C_BIT_RXSEL] | ctrl_q[T2C_BIT_TXSEL];
    down_en = mode_q[T2C_BIT_DOWN];
    if (!ctrl_q[T2C_BIT_TR]) begin
      mode = T2C_OFF;
    end else if (baud) begin
      mode = T2C_BAUD;
    end else if (ctrl_q[T2C_BIT_CPRL]) begin
      mode = T2C_CAPTURE;
    end else begin
      mode = T2C_RELOAD;
    end
    pre_d = (pre_q == T2C_MC_CLKS - 4'd1) ? 4'd0 : 4'(pre_q + 4'd1);
    mc_tick = (pre_q == T2C_MC_CLKS - 4'd1);
    // Baud timing steps once per state time, six times a machine cycle
    st_tick = (pre_q[0] == T2C_STATE_CLKS[0]);
    // Counter mode takes the synchronised event edge
    if (ctrl_q[T2C_BIT_CT]) begin
      inc = evt.fall;
    end else begin
      inc = baud ? st_tick : mc_tick;
    end
    trig_ev = ctrl_q[T2C_BIT_EXEN] & trig.fall;
    reload_dir_up = !down_en || trig.level;
  end

  // ----------------------------------------------------------------
  // Counter, capture/reload and flag events
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    rcap_d = rcap_q;
    ovf = 1'b0;
    tog_exf = 1'b0;
    set_exf = 1'b0;
    case (mode)
      T2C_RELOAD: begin
        if (inc && reload_dir_up) begin
          if (cnt_q == T2C_CNT_MAX) begin
            cnt_d = rcap_q;
            ovf = 1'b1;
            tog_exf = down_en;
          end else begin
            cnt_d = 16'(cnt_q + 16'd1);
          end
        end else if (inc) begin
          if (cnt_q == rcap_q) begin
            cnt_d = T2C_CNT_MAX;
            ovf = 1'b1;
            tog_exf = 1'b1;
          end else begin
            cnt_d = 16'(cnt_q - 16'd1);
          end
        end
      end
      T2C_CAPTURE: begin
        if (inc) begin
          cnt_d = 16'(cnt_q + 16'd1);
          ovf = (cnt_q == T2C_CNT_MAX);
        end
      end
      T2C_BAUD: begin
        if (inc) begin
          if (cnt_q == T2C_CNT_MAX) begin
            cnt_d = rcap_q;
            ovf = 1'b1;
          end else begin
            cnt_d = 16'(cnt_q + 16'd1);
          end
        end
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    // Trigger edges act even while stopped; in up/down mode the pin is direction only
    if (trig_ev && !(down_en && !baud && !ctrl_q[T2C_BIT_CPRL])) begin
      set_exf = 1'b1;
      if (!baud && ctrl_q[T2C_BIT_CPRL]) begin
        rcap_d = cnt_q;
      end else if (!baud) begin
        cnt_d = rcap_q;
      end
    end
    set_tf = ovf && !baud;
    // Software byte writes win over counting in the same cycle
    wr_cnt = SFR_WR_I && (SFR_ADDR_I == T2C_ADDR_CNT_L || SFR_ADDR_I == T2C_ADDR_CNT_H);
    wr_rcap = SFR_WR_I && (SFR_ADDR_I == T2C_ADDR_RCAP_L || SFR_ADDR_I == T2C_ADDR_RCAP_H);
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_CNT_L) begin
      cnt_d[7:0] = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_CNT_H) begin
      cnt_d[15:8] = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_RCAP_L) begin
      rcap_d[7:0] = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_RCAP_H) begin
      rcap_d[15:8] = SFR_WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Control, mode and interrupt registers
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl = (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_CTRL) || SFR_BIT_WR_I;
    ctrl_sw = ctrl_q;
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_CTRL) begin
      ctrl_sw = SFR_WDATA_I;
    end else if (SFR_BIT_WR_I) begin
      ctrl_sw[SFR_BIT_SEL_I] = SFR_BIT_VAL_I;
    end
    ctrl_d = ctrl_sw;
    // Hardware set beats a software clear landing in the same cycle
    if (set_tf) begin
      ctrl_d[T2C_BIT_TF] = 1'b1;
    end
    if (set_exf) begin
      ctrl_d[T2C_BIT_EXF] = 1'b1;
    end else if (tog_exf) begin
      ctrl_d[T2C_BIT_EXF] = ~ctrl_q[T2C_BIT_EXF];
    end
    mode_d = mode_q;
    inten_d = inten_q;
    prio_d = prio_q;
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_MODE) begin
      mode_d = SFR_WDATA_I & T2C_MASK_MODE;
    end
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_INTEN) begin
      inten_d = SFR_WDATA_I & T2C_MASK_INTEN;
    end
    if (SFR_WR_I && SFR_ADDR_I == T2C_ADDR_PRIO) begin
      prio_d = SFR_WDATA_I & T2C_MASK_PRIO;
    end
  end

  // ----------------------------------------------------------------
  // Read data and registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        T2C_ADDR_CTRL: rdata_d = ctrl_q;
        T2C_ADDR_MODE: rdata_d = mode_q;
        T2C_ADDR_RCAP_L: rdata_d = rcap_q[7:0];
        T2C_ADDR_RCAP_H: rdata_d = rcap_q[15:8];
        T2C_ADDR_CNT_L: rdata_d = cnt_q[7:0];
        T2C_ADDR_CNT_H: rdata_d = cnt_q[15:8];
        T2C_ADDR_INTEN: rdata_d = inten_q;
        T2C_ADDR_PRIO: rdata_d = prio_q;
        // Other addresses belong to other blocks; zero lets the core OR read buses
        default: rdata_d = 8'h00;
      endcase
    end
    irq_d = inten_q[T2C_BIT_EA] && inten_q[T2C_BIT_ET2] &&
            (ctrl_q[T2C_BIT_TF] || (ctrl_q[T2C_BIT_EXF] && !down_en));
    hipri_d = prio_q[T2C_BIT_PT2];
    rx_tick_d = ctrl_q[T2C_BIT_RXSEL] ? ovf : TIMER1_OVF_I;
    tx_tick_d = ctrl_q[T2C_BIT_TXSEL] ? ovf : TIMER1_OVF_I;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl_q <= T2C_RST_CTRL;
      mode_q <= T2C_RST_MODE;
      inten_q <= T2C_RST_INTEN;
      prio_q <= T2C_RST_PRIO;
      rcap_q <= T2C_RST_RCAP;
      cnt_q <= T2C_RST_CNT;
      pre_q <= 4'd0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      hipri_q <= 1'b0;
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      inten_q <= inten_d;
      prio_q <= prio_d;
      rcap_q <= rcap_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      hipri_q <= hipri_d;
      rx_tick_q <= rx_tick_d;
      tx_tick_q <= tx_tick_d;
    end
  end

  assign SFR_RDATA_O = rdata_q;
  assign TIMER_IRQ_O = irq_q;
  assign TIMER_IRQ_HIPRI_O = hipri_q;
  assign INT_EN_O = inten_q;
  assign INT_PRIO_O = prio_q;
  assign RX_CLK_TICK_O = rx_tick_q;
  assign TX_CLK_TICK_O = tx_tick_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  tf_set_a: assert property (set_tf |=> ctrl_q[T2C_BIT_TF])
    else $error("overflow flag not set after overflow");
  tf_hold_a: assert property (ctrl_q[T2C_BIT_TF] && !wr_ctrl |=> ctrl_q[T2C_BIT_TF])
    else $error("overflow flag cleared without software write");
  tf_baud_a: assert property (baud && !ctrl_q[T2C_BIT_TF] && !wr_ctrl |=> !ctrl_q[T2C_BIT_TF])
    else $error("overflow flag set in serial clock mode");
  exf_set_a: assert property (trig_ev && !down_en |=> ctrl_q[T2C_BIT_EXF])
    else $error("external flag not set by trigger edge");
  irq_exf_a: assert property (inten_q[T2C_BIT_EA] && inten_q[T2C_BIT_ET2] && ctrl_q[T2C_BIT_EXF] && !down_en
    |=> TIMER_IRQ_O)
    else $error("external flag did not raise interrupt");
  irq_down_a: assert property (down_en && !ctrl_q[T2C_BIT_TF] |=> !TIMER_IRQ_O)
    else $error("external flag raised interrupt in up/down mode");
  rx_sel_a: assert property (ctrl_q[T2C_BIT_RXSEL] && ovf |=> RX_CLK_TICK_O)
    else $error("receive tick missing on overflow");
  tx_sel_a: assert property (!ctrl_q[T2C_BIT_TXSEL] |=> TX_CLK_TICK_O == $past(TIMER1_OVF_I))
    else $error("transmit tick not from other timer");
  trig_off_a: assert property (!ctrl_q[T2C_BIT_EXEN] && !wr_rcap |=> $stable(rcap_q))
    else $error("trigger acted while external enable clear");
  run_off_a: assert property (!ctrl_q[T2C_BIT_TR] && !trig_ev && !wr_cnt |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  capture_a: assert property (mode == T2C_CAPTURE && trig_ev && !wr_rcap
    |=> rcap_q == $past(cnt_q))
    else $error("capture missed trigger edge");
  baud_rld_a: assert property (mode == T2C_BAUD && inc && cnt_q == T2C_CNT_MAX && !wr_cnt
    |=> cnt_q == $past(rcap_q))
    else $error("no reload on overflow in serial clock mode");
endmodule
`default_nettype wire

// ==== t2c_core_model.sv ====
// Partner model: core software bus access, other timer overflows, baud tick counting
`timescale 1ns/1ps
`default_nettype none
module t2c_core_model (
  input wire logic clk_i,
  input wire t2c_pkg::t2c_byte_t rdata_i,
  input wire logic rx_tick_i,
  input wire logic tx_tick_i,
  output var t2c_pkg::t2c_byte_t addr_o,
  output var t2c_pkg::t2c_byte_t wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic bit_wr_o,
  output var logic [2:0] bit_sel_o,
  output var logic bit_val_o,
  output var logic t1_ovf_o
);
  import t2c_pkg::*;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int t1_cnt = 0;
  int t1_div = 0;
  logic t1_run = 1'b0;
  // ------------------------------------------------------------
  // Bus strobes and the other timer
  // ------------------------------------------------------------
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    bit_wr_o = 1'b0;
    bit_sel_o = 3'h0;
    bit_val_o = 1'b0;
  end
  // Idle address and data show the inverse so a stale value never looks valid
  task automatic wr(input t2c_byte_t a, input t2c_byte_t d);
    @(posedge clk_i) #1;
    addr_o = a;
    wdata_o = (a == T2C_ADDR_MODE) ? (d & T2C_MASK_MODE) : d;
    wr_o = 1'b1;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input t2c_byte_t a, output t2c_byte_t d);
    @(posedge clk_i) #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i) #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  task automatic bwr(input logic [2:0] s, input logic v);
    @(posedge clk_i) #1;
    bit_sel_o = s;
    bit_val_o = v;
    bit_wr_o = 1'b1;
    @(posedge clk_i) #1;
    bit_wr_o = 1'b0;
    bit_sel_o = ~s;
    bit_val_o = ~v;
  endtask
  task automatic clr();
    rx_cnt = 0;
    tx_cnt = 0;
    t1_cnt = 0;
  endtask
  always @(posedge clk_i) begin
    if (rx_tick_i === 1'b1) begin
      rx_cnt++;
    end
    if (tx_tick_i === 1'b1) begin
      tx_cnt++;
    end
    if (t1_ovf_o === 1'b1) begin
      t1_cnt++;
    end
    t1_div <= (t1_div == 4) ? 0 : t1_div + 1;
    t1_ovf_o <= t1_run && (t1_div == 4);
  end
endmodule
`default_nettype wire

// ==== test_timer2_control_status.sv ====
// Self-checking bench for the timer-2 control and status block
`timescale 1ns/1ps
`default_nettype none
module test_timer2_control_status;
  import t2c_pkg::*;
  logic MCLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic trig = 1'b1;
  logic evt = 1'b1;
  t2c_byte_t a, wd, rdat, ien, ipr;
  logic wr, rd, bw, bv, t1, irq, hip, rxt, txt;
  logic [2:0] bs;
  int err_total = 0;
  int checks_done = 0;
  always #25 MCLK_I = ~MCLK_I;
  t2c_core_model core_u (.clk_i(MCLK_I), .rdata_i(rdat), .rx_tick_i(rxt), .tx_tick_i(txt), .addr_o(a),
    .wdata_o(wd), .wr_o(wr), .rd_o(rd), .bit_wr_o(bw), .bit_sel_o(bs), .bit_val_o(bv), .t1_ovf_o(t1));
  t2c_timer2 dut_u (.MCLK_I(MCLK_I), .RST_I(RST_I), .SFR_ADDR_I(a), .SFR_WR_I(wr), .SFR_WDATA_I(wd),
    .SFR_RD_I(rd), .SFR_BIT_WR_I(bw), .SFR_BIT_SEL_I(bs), .SFR_BIT_VAL_I(bv), .TRIG_PIN_I(trig),
    .EVENT_PIN_I(evt), .TIMER1_OVF_I(t1), .SFR_RDATA_O(rdat), .TIMER_IRQ_O(irq), .TIMER_IRQ_HIPRI_O(hip),
    .INT_EN_O(ien), .INT_PRIO_O(ipr), .RX_CLK_TICK_O(rxt), .TX_CLK_TICK_O(txt));
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rdchk(input string nm, input t2c_byte_t ad, input t2c_byte_t exp);
    t2c_byte_t d;
    core_u.rd(ad, d);
    chk(nm, 16'(d), 16'(exp));
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rdchk("reset_read", 8'hC8 + 8'(i), 8'h00);
    end
    rdchk("mode_reset", T2C_ADDR_MODE, T2C_RST_MODE);
    chk("ie_reset", 16'(ien), 16'h0000);
    chk("ip_reset", 16'(ipr), 16'h0000);
  endtask
  task automatic t_overflow();
    t2c_byte_t d;
    int n;
    core_u.wr(T2C_ADDR_RCAP_L, 8'h34);
    core_u.wr(T2C_ADDR_RCAP_H, 8'h12);
    core_u.wr(T2C_ADDR_CNT_L, 8'hFE);
    core_u.wr(T2C_ADDR_CNT_H, 8'hFF);
    core_u.wr(T2C_ADDR_CTRL, 8'h04);
    d = 8'h00;
    n = 0;
    while (d[T2C_BIT_TF] !== 1'b1 && n < 60) begin
      core_u.rd(T2C_ADDR_CTRL, d);
      n++;
    end
    if (d[T2C_BIT_TF] !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    core_u.bwr(3'd2, 1'b0);
    rdchk("ctrl_bit_wr", T2C_ADDR_CTRL, 8'h80);
    rdchk("reload_high", T2C_ADDR_CNT_H, 8'h12);
    core_u.wr(T2C_ADDR_INTEN, 8'hFF);
    core_u.wr(T2C_ADDR_PRIO, 8'hFF);
    cyc(3);
    chk("irq_overflow", 16'(irq), 16'h0001);
    chk("irq_prio", 16'(hip), 16'h0001);
    chk("ie_out", 16'(ien), 16'h00BF);
    chk("ip_out", 16'(ipr), 16'h003F);
    core_u.bwr(3'd7, 1'b0);
    cyc(3);
    chk("irq_cleared", 16'(irq), 16'h0000);
  endtask
  task automatic t_capture();
    core_u.wr(T2C_ADDR_CNT_L, 8'hCD);
    core_u.wr(T2C_ADDR_CNT_H, 8'hAB);
    core_u.wr(T2C_ADDR_CTRL, 8'h09);
    trig = 1'b0;
    cyc(8);
    rdchk("cap_low", T2C_ADDR_RCAP_L, 8'hCD);
    rdchk("cap_high", T2C_ADDR_RCAP_H, 8'hAB);
    rdchk("cap_flag", T2C_ADDR_CTRL, 8'h49);
    core_u.wr(T2C_ADDR_CTRL, 8'h01);
    trig = 1'b1;
    core_u.wr(T2C_ADDR_CNT_H, 8'h11);
    trig = 1'b0;
    cyc(8);
    rdchk("ignored_high", T2C_ADDR_RCAP_H, 8'hAB);
    rdchk("ignored_flag", T2C_ADDR_CTRL, 8'h01);
    core_u.wr(T2C_ADDR_CTRL, 8'h08);
    trig = 1'b1;
    cyc(4);
    trig = 1'b0;
    cyc(8);
    rdchk("trig_reload", T2C_ADDR_CNT_H, 8'hAB);
    rdchk("reload_flag", T2C_ADDR_CTRL, 8'h48);
    trig = 1'b1;
    core_u.wr(T2C_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_baud();
    core_u.wr(T2C_ADDR_RCAP_L, 8'hFC);
    core_u.wr(T2C_ADDR_RCAP_H, 8'hFF);
    core_u.wr(T2C_ADDR_CNT_L, 8'hFC);
    core_u.wr(T2C_ADDR_CNT_H, 8'hFF);
    core_u.wr(T2C_ADDR_CTRL, 8'h34);
    core_u.clr();
    cyc(100);
    rdchk("baud_no_flag", T2C_ADDR_CTRL, 8'h34);
    chk("baud_ticks", 16'(core_u.rx_cnt > 5), 16'h0001);
    chk("rx_eq_tx", 16'(core_u.rx_cnt == core_u.tx_cnt), 16'h0001);
    core_u.wr(T2C_ADDR_CTRL, 8'h14);
    // A receive tick from the own timer may still be in flight
    cyc(2);
    core_u.t1_run = 1'b1;
    core_u.clr();
    cyc(100);
    core_u.t1_run = 1'b0;
    cyc(4);
    chk("rx_other", 16'(core_u.rx_cnt == core_u.t1_cnt && core_u.t1_cnt > 5), 16'h0001);
    chk("tx_own", 16'(core_u.tx_cnt > 5), 16'h0001);
    core_u.wr(T2C_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_counter();
    core_u.wr(T2C_ADDR_CNT_L, 8'h00);
    for (int k = 0; k < 2; k++) begin
      core_u.wr(T2C_ADDR_CTRL, k ? 8'h06 : 8'h02);
      repeat (3) begin
        evt = 1'b0;
        cyc(4);
        evt = 1'b1;
        cyc(4);
      end
      rdchk("event_count", T2C_ADDR_CNT_L, k ? 8'h03 : 8'h00);
    end
    core_u.wr(T2C_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_down_count_enable();
    core_u.wr(T2C_ADDR_CTRL, 8'h40);
    core_u.wr(T2C_ADDR_MODE, 8'h01);
    cyc(3);
    chk("irq_down_count_enable", 16'(irq), 16'h0000);
    rdchk("mode_read", T2C_ADDR_MODE, 8'h01);
    core_u.wr(T2C_ADDR_MODE, 8'h00);
    cyc(3);
    chk("irq_ext", 16'(irq), 16'h0001);
    core_u.wr(T2C_ADDR_CTRL, 8'h00);
    // Down count with trigger low: underflow at the reload value loads all ones
    core_u.wr(T2C_ADDR_RCAP_L, 8'h10);
    core_u.wr(T2C_ADDR_RCAP_H, 8'h20);
    core_u.wr(T2C_ADDR_CNT_L, 8'h11);
    core_u.wr(T2C_ADDR_CNT_H, 8'h20);
    core_u.wr(T2C_ADDR_MODE, 8'h01);
    trig = 1'b0;
    core_u.wr(T2C_ADDR_CTRL, 8'h04);
    cyc(40);
    core_u.bwr(3'd2, 1'b0);
    rdchk("down_high", T2C_ADDR_CNT_H, 8'hFF);
    rdchk("down_flags", T2C_ADDR_CTRL, 8'hC0);
    trig = 1'b1;
    core_u.wr(T2C_ADDR_MODE, 8'h00);
    core_u.wr(T2C_ADDR_CTRL, 8'h00);
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    cyc(6);
    RST_I = 1'b0;
    cyc(2);
    t_reset();
    $display("reset test done");
    t_overflow();
    $display("overflow test done");
    t_capture();
    $display("capture test done");
    t_baud();
    $display("baud test done");
    t_counter();
    $display("counter test done");
    t_down_count_enable();
    $display("down count test done");
    print_verdict();
  end
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
